// ==== src/tmc_pin_sync.sv ====
// Purpose: Bring the external count pin into the clock domain.
// Assumes: The pin keeps its minimum high and low times.
// Notes: The output is inverted when falling edges are to count.
`timescale 1ns/1ps
module tmc_pin_sync (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic pin_in,
    input wire logic falling_sel_in,
    output logic level_out
);
    logic meta;
    logic stable;

    // Two-stage synchroniser; only the second stage is looked at.
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            meta <= 1'b0;
            stable <= 1'b0;
        end else begin
            meta <= pin_in;
            stable <= meta;
        end
    end

    // Polarity turns the wanted edge into a rising one.
    assign level_out = stable ^ falling_sel_in;

endmodule

// ==== src/tmc_pkg.sv ====
// Purpose: Shared constants for the eight-bit timer/counter block.
// Assumes: One word per register on APB, byte addresses below.
// Notes: The option word resets to all ones in its low six bits.
package tmc_pkg;

    // Register byte addresses on the APB side.
    localparam logic [11:0] ADDR_COUNT = 12'h000;
    localparam logic [11:0] ADDR_OPTION = 12'h004;
    localparam logic [11:0] ADDR_INTCTL = 12'h008;

    // Option word field positions.
    localparam int OPT_SRC_SEL = 5;
    localparam int OPT_EDGE_SEL = 4;
    localparam int OPT_BYPASS = 3;
    localparam int OPT_RATE_LO = 0;

    // Interrupt control field positions.
    localparam int INT_ENABLE = 5;
    localparam int INT_FLAG = 2;

    // Reset values and the count maximum.
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] OPTION_RESET = 8'h3F;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    // Timing: the system clock is the oscillator, four per instruction.
    localparam int OSC_PER_INSTR = 4;
    localparam int WRITE_INHIBIT_INSTR = 2;
    localparam logic [1:0] INHIBIT_LOAD = 2'(WRITE_INHIBIT_INSTR);

    // Instruction clock phases, Gray coded along the cycle.
    typedef enum logic [1:0] {
        PH_Q1 = 2'b00,
        PH_Q2 = 2'b01,
        PH_Q3 = 2'b11,
        PH_Q4 = 2'b10
    } tmc_phase_t;

endpackage

// ==== src/tmc_prescaler.sv ====
// Purpose: Dedicated divide-by-2 to divide-by-256 prescaler.
// Assumes: src_in is a clean synchronous level.
// Notes: Software cannot see or load the counter, only clear it.
`timescale 1ns/1ps
module tmc_prescaler (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic src_in,
    input wire logic clear_in,
    input wire logic run_in,
    input wire logic bypass_in,
    input wire logic [2:0] rate_in,
    output logic div_out
);
    logic src_prev;
    logic [7:0] div_count;
    wire src_rise = src_in & ~src_prev;

    // Count source rising edges; a count write empties the divider.
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            src_prev <= 1'b0;
            div_count <= 8'h00;
        end else begin
            src_prev <= src_in;
            if (clear_in || bypass_in) begin
                div_count <= 8'h00;
            end else if (run_in && src_rise) begin
                div_count <= div_count + 8'h01;
            end
        end
    end

    // Bit n rises once every 2^(n+1) edges; bypass passes the source on.
    assign div_out = bypass_in ? src_in : div_count[rate_in];

endmodule

// ==== src/tmc_timer.sv ====
// Purpose: Eight-bit timer/counter with prescaler, APB registers.
// Assumes: sys_clk_in is the oscillator; four clocks per instruction.
// Notes: Registers answer in the first access cycle, with no wait state.
//
// Contract
// - One readable, writable eight-bit count register
// - Source select clear: count each instruction cycle
// - No counting two instruction cycles after write
// - Source select set: count external pin edges
// - Edge select chooses rising or falling edge
// - Prescaler used only while bypass is clear
// - Eight prescale ratios, two to 256
// - Bypass set gives undivided one-to-one counting
// - Prescaler hidden; count write clears it
// - Wrap from maximum to zero is overflow
// - Flag always sets; request needs enable
// - Flag cleared only by software writing zero
// - Sleep freezes counting and holds value
// - Counter mode sampled at second, fourth phase
// - Overflow offered as sixteen-bit timer gate
// - Prescaler dedicated, separate from watchdog
// - Edge select one counts falling, zero rising
// - Ratio is two to rate plus one
// - Timer source is oscillator divided by four
`timescale 1ns/1ps
module tmc_timer (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic count_pin_in,
    input wire logic sleep_in,
    output logic overflow_irq_out,
    output logic overflow_gate_out
);

    // Instruction phase and configuration state.
    tmc_pkg::tmc_phase_t phase;
    tmc_pkg::tmc_phase_t next_phase;
    logic [7:0] count_register;
    logic src_select;
    logic edge_select;
    logic bypass;
    logic [2:0] prescale_rate;
    logic int_enable;
    logic overflow_flag;
    logic [1:0] inhibit;
    logic sampled;

    // Derived wires.
    logic pin_level;
    logic instr_level;
    logic source_level;
    logic div_level;
    logic sample_now;
    logic cycle_end;
    logic inc_now;
    logic wraps;

    // APB decode wires.
    logic setup_phase;
    logic access_done;
    logic wr_done;
    logic hit_count;
    logic hit_option;
    logic hit_intctl;
    logic hit_any;
    logic wr_count;
    logic wr_option;
    logic wr_intctl;
    logic [31:0] read_word;
    logic [7:0] option_word;
    logic [7:0] intctl_word;

    // Phase stepping. A reset starts a fresh instruction at Q1.
    always_comb begin
        unique case (phase)
            tmc_pkg::PH_Q1: next_phase = tmc_pkg::PH_Q2;
            tmc_pkg::PH_Q2: next_phase = tmc_pkg::PH_Q3;
            tmc_pkg::PH_Q3: next_phase = tmc_pkg::PH_Q4;
            tmc_pkg::PH_Q4: next_phase = tmc_pkg::PH_Q1;
        endcase
    end

    // The phase runs through sleep; only the counting path stops.
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            phase <= tmc_pkg::PH_Q1;
        end else begin
            phase <= next_phase;
        end
    end

    // The instruction clock is high in Q3 and Q4, so it has one
    // rising edge per four oscillator clocks.
    assign instr_level = (phase == tmc_pkg::PH_Q3) | (phase == tmc_pkg::PH_Q4);
    assign cycle_end = (phase == tmc_pkg::PH_Q4);

    // External pin path; polarity is applied before the prescaler.
    tmc_pin_sync u_pin_sync (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .pin_in(count_pin_in),
        .falling_sel_in(edge_select),
        .level_out(pin_level)
    );

    // Source choice between the instruction clock and the pin.
    assign source_level = src_select ? pin_level : instr_level;

    // This prescaler belongs to the timer alone; the watchdog keeps
    // its own divider and none of these settings reach it.
    tmc_prescaler u_prescaler (
        .sys_clk_in(sys_clk_in),
        .rstn_in(rstn_in),
        .src_in(source_level),
        .clear_in(wr_count),
        .run_in(~sleep_in),
        .bypass_in(bypass),
        .rate_in(prescale_rate),
        .div_out(div_level)
    );

    // The divider output is looked at only in Q2 and Q4. This keeps
    // an asynchronous pin from stepping the count mid-instruction,
    // at the cost of pins faster than half an instruction cycle.
    assign sample_now = (phase == tmc_pkg::PH_Q2) | cycle_end;

    // A rising sampled level steps the count once, prescaled or not,
    // unless sleeping or still inside the window after a write.
    assign inc_now = sample_now & div_level & ~sampled & ~sleep_in
        & (inhibit == 2'b00);

    // Wrap from the top value to zero.
    assign wraps = inc_now & (count_register == tmc_pkg::COUNT_MAX);

    // APB phase decode.
    assign setup_phase = psel_in & ~penable_in;
    assign access_done = psel_in & penable_in & pready_out;
    assign wr_done = access_done & pwrite_in;

    // Address decode. The prescaler has no address at all.
    assign hit_count = (paddr_in == tmc_pkg::ADDR_COUNT);
    assign hit_option = (paddr_in == tmc_pkg::ADDR_OPTION);
    assign hit_intctl = (paddr_in == tmc_pkg::ADDR_INTCTL);
    assign hit_any = hit_count | hit_option | hit_intctl;

    // Write strobes, one per register, on the completing edge.
    assign wr_count = wr_done & hit_count;
    assign wr_option = wr_done & hit_option;
    assign wr_intctl = wr_done & hit_intctl;

    // Read views; unused bits read as zero.
    assign option_word = {2'b00, src_select, edge_select, bypass, prescale_rate};
    assign intctl_word = {2'b00, int_enable, 2'b00, overflow_flag, 2'b00};

    // Read multiplexer; unmapped addresses read zero.
    assign read_word = hit_count ? {24'h00_0000, count_register} :
        hit_option ? {24'h00_0000, option_word} :
        hit_intctl ? {24'h00_0000, intctl_word} : tmc_pkg::WORD_ZERO;

    // Bus answer: ready and data are raised on the edge that ends the
    // setup phase, so every transfer completes at its first access
    // edge. Unmapped addresses complete with an error.
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= tmc_pkg::WORD_ZERO;
        end else begin
            pready_out <= setup_phase;
            pslverr_out <= setup_phase & ~hit_any;
            if (setup_phase && !pwrite_in) begin
                prdata_out <= read_word;
            end
        end
    end

    // Configuration fields live in the option word.
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            src_select <= tmc_pkg::OPTION_RESET[tmc_pkg::OPT_SRC_SEL];
            edge_select <= tmc_pkg::OPTION_RESET[tmc_pkg::OPT_EDGE_SEL];
            bypass <= tmc_pkg::OPTION_RESET[tmc_pkg::OPT_BYPASS];
            prescale_rate <= tmc_pkg::OPTION_RESET[tmc_pkg::OPT_RATE_LO +: 3];
        end else if (wr_option) begin
            src_select <= pwdata_in[tmc_pkg::OPT_SRC_SEL];
            edge_select <= pwdata_in[tmc_pkg::OPT_EDGE_SEL];
            bypass <= pwdata_in[tmc_pkg::OPT_BYPASS];
            prescale_rate <= pwdata_in[tmc_pkg::OPT_RATE_LO +: 3];
        end
    end

    // The count register. A write wins over a same-cycle step, so
    // the written value is never bumped before software sees it.
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            count_register <= tmc_pkg::COUNT_RESET;
        end else if (wr_count) begin
            count_register <= pwdata_in[7:0];
        end else if (inc_now) begin
            count_register <= count_register + 8'h01;
        end
    end

    // Write inhibit: loaded on a count write and worn down once per
    // instruction end, covering the rest of the writing instruction and the next one, or the next two for a write in Q4.
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            inhibit <= 2'b00;
        end else if (wr_count) begin
            inhibit <= tmc_pkg::INHIBIT_LOAD;
        end else if (cycle_end && inhibit != 2'b00) begin
            inhibit <= inhibit - 2'b01;
        end
    end

    // Held sample of the divider output. It keeps tracking during the
    // inhibit window so a level that is already high does not count
    // as a fresh edge when the window closes. Frozen in sleep.
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            // The pin rests low, so after reset the polarity bit alone sets
            // the idle level; matching it keeps a false edge from counting.
            sampled <= tmc_pkg::OPTION_RESET[tmc_pkg::OPT_EDGE_SEL];
        end else if (sample_now && !sleep_in) begin
            sampled <= div_level;
        end
    end

    // Interrupt control: the enable is plain storage. The flag is set
    // by every wrap whatever the enable says, and hardware never
    // clears it; software writes zero. A wrap in the same cycle as a
    // clearing write still leaves the flag set.
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            int_enable <= 1'b0;
            overflow_flag <= 1'b0;
        end else begin
            if (wr_intctl) begin
                int_enable <= pwdata_in[tmc_pkg::INT_ENABLE];
            end
            if (wraps) begin
                overflow_flag <= 1'b1;
            end else if (wr_intctl) begin
                overflow_flag <= pwdata_in[tmc_pkg::INT_FLAG];
            end
        end
    end

    // Outputs. The request follows the flag gated by the enable; the
    // gate pulse marks each wrap for the sixteen-bit timer.
    always_ff @(posedge sys_clk_in) begin
        if (!rstn_in) begin
            overflow_irq_out <= 1'b0;
            overflow_gate_out <= 1'b0;
        end else begin
            overflow_irq_out <= overflow_flag & int_enable;
            overflow_gate_out <= wraps;
        end
    end

endmodule

// ==== verification/tmc_pin_model.sv ====
// Purpose: External count pin source for counter-mode scenarios.
// Assumes: The pin is a plain driven level, resting low.
// Notes: Each level is held long enough for sync and phase sampling.
`timescale 1ns/1ps
module tmc_pin_model (
    input wire logic sys_clk_in,
    output logic pin_out
);
    initial pin_out = 1'b0;
    // Holding 8 clocks keeps high and low times above the sync and sample latency.
    task automatic toggle();
        @(posedge sys_clk_in);
        pin_out <= ~pin_out;
        repeat (8) @(posedge sys_clk_in);
    endtask
endmodule

// ==== verification/tmc_timer_asserts.sv ====
// Purpose: Port-level timing checks for the eight-bit timer block.
// Assumes: One clock, synchronous active-low reset.
// Notes: Gate and irq timing allow one clock of registering slack.
`timescale 1ns/1ps
module tmc_timer_asserts (
    input wire logic sys_clk_in,
    input wire logic rstn_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic sleep_in,
    input wire logic overflow_irq_out,
    input wire logic overflow_gate_out
);
    // A completed write to interrupt control is the only software cause of an irq change.
    logic ctl_wr;
    assign ctl_wr = psel_in && penable_in && pwrite_in && paddr_in == tmc_pkg::ADDR_INTCTL;
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rstn_in);

    chk_ready_after_setup: assert property (psel_in && !penable_in |=> pready_out)
        else $error("pready missing after setup");
    chk_ready_one_cycle: assert property (pready_out |=> !pready_out)
        else $error("pready held too long");
    chk_unmapped_data: assert property (pready_out && pslverr_out && !pwrite_in
        |-> prdata_out == 32'h0000_0000)
        else $error("error read returned data");
    chk_gate_pulse_gap: assert property (overflow_gate_out |=> !overflow_gate_out [*4])
        else $error("gate pulse too long or too close");
    // A wrap needs a running count, so two cycles of sleep rule out a gate pulse.
    chk_sleep_no_wrap: assert property ($past(sleep_in) && $past(sleep_in, 2)
        |-> !overflow_gate_out)
        else $error("overflow while asleep");
    chk_irq_rise_cause: assert property ($rose(overflow_irq_out) |->
        overflow_gate_out || $past(overflow_gate_out) || $past(ctl_wr, 2))
        else $error("irq rose without overflow or write");
    chk_irq_fall_cause: assert property ($fell(overflow_irq_out) |-> $past(ctl_wr, 2))
        else $error("irq cleared by hardware");
    chk_no_err_mapped: assert property (pready_out
        && $past(paddr_in) == tmc_pkg::ADDR_COUNT |-> !pslverr_out)
        else $error("error on mapped count access");
endmodule

bind tmc_timer tmc_timer_asserts i_chk (.sys_clk_in, .rstn_in, .psel_in, .penable_in, .pwrite_in,
    .paddr_in, .prdata_out, .pready_out, .pslverr_out, .sleep_in, .overflow_irq_out,
    .overflow_gate_out);

// ==== verification/tmc_timer_bench.sv ====
// Purpose: Self-checking bench for the eight-bit timer block.
// Assumes: APB answers with pready; four clocks per instruction.
// Notes: Timing windows allow for the write phase within an instruction.
`timescale 1ns/1ps
module tmc_timer_bench;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, sleep = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, q;
    logic pready, pslverr, irq, gate, pin, e;
    int mismatches = 0, check_count = 0, cyc = 0;
    tmc_timer i_dut (.sys_clk_in(clk), .rstn_in(rstn), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .count_pin_in(pin), .sleep_in(sleep),
        .overflow_irq_out(irq), .overflow_gate_out(gate));
    tmc_pin_model i_pin (.sys_clk_in(clk), .pin_out(pin));
    // 50 MHz clock and a free-running cycle count for timing checks.
    initial forever #10 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic fail(input string m);
        $display("ERROR %0t %s", $time, m);
        mismatches++;
    endtask
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) fail($sformatf("word %h expected %h", g, x));
    endtask
    task automatic cmp_bit(input logic g, input logic x);
        check_count++;
        if (g !== x) fail($sformatf("bit %b expected %b", g, x));
    endtask
    task automatic cmp_span(input int g, input int lo, input int hi);
        check_count++;
        if (g < lo || g > hi) fail($sformatf("span %0d outside %0d..%0d", g, lo, hi));
    endtask
    // One APB transfer; an idle edge follows so psel is never set twice in one step.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (n >= 20) begin
            fail("no pready");
            print_verdict();
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, '0);
        cmp_word(q, x);
    endtask
    // Reads the count until it shows v; resolution is one read, three clocks.
    task automatic poll(input logic [7:0] v);
        int n;
        n = 0;
        do begin
            apb(1'b0, tmc_pkg::ADDR_COUNT, '0);
            n++;
        end while (q[7:0] !== v && n < 1000);
        if (n >= 1000) begin
            fail("count stuck");
            print_verdict();
        end
    endtask

    task automatic t_reset();
        rd(tmc_pkg::ADDR_COUNT, 32'h0000_0000);
        rd(tmc_pkg::ADDR_OPTION, 32'h0000_003F);
        rd(tmc_pkg::ADDR_INTCTL, 32'h0000_0000);
        rd(12'h00C, 32'h0000_0000);
        cmp_bit(e, 1'b1);
        // The resting pin must not count a false edge once reset is gone.
        rd(tmc_pkg::ADDR_COUNT, 32'h0000_0000);
        $display("reset values done");
    endtask
    // Step 8 is bypass with rate 7, which must give one count per instruction.
    task automatic t_rates();
        int t;
        int p;
        for (int r = 0; r < 9; r++) begin
            p = (r == 8) ? 4 : 8 << r;
            apb(1'b1, tmc_pkg::ADDR_OPTION, (r == 8) ? 32'h0000_000F : 32'(r));
            apb(1'b1, tmc_pkg::ADDR_COUNT, '0);
            poll(8'h01);
            t = cyc;
            poll(8'h02);
            cmp_span(cyc - t, p - 2, p + 2);
        end
        $display("prescale rates done");
    endtask
    task automatic t_overflow();
        int n;
        n = 0;
        apb(1'b1, tmc_pkg::ADDR_OPTION, 32'h0000_0008);
        apb(1'b1, tmc_pkg::ADDR_INTCTL, '0);
        apb(1'b1, tmc_pkg::ADDR_COUNT, 32'h0000_00FF);
        do begin
            @(posedge clk);
            n++;
        end while (gate !== 1'b1 && n < 40);
        cmp_span(n, 9, 12);
        repeat (3) @(posedge clk);
        cmp_bit(irq, 1'b0);
        rd(tmc_pkg::ADDR_INTCTL, 32'h0000_0004);
        apb(1'b1, tmc_pkg::ADDR_INTCTL, 32'h0000_0024);
        @(posedge clk);
        cmp_bit(irq, 1'b1);
        rd(tmc_pkg::ADDR_INTCTL, 32'h0000_0024);
        apb(1'b1, tmc_pkg::ADDR_INTCTL, 32'h0000_0020);
        @(posedge clk);
        cmp_bit(irq, 1'b0);
        rd(tmc_pkg::ADDR_INTCTL, 32'h0000_0020);
        $display("overflow flag done");
    endtask
    task automatic t_sleep();
        sleep <= 1'b1;
        apb(1'b1, tmc_pkg::ADDR_COUNT, 32'h0000_00FF);
        repeat (40) @(posedge clk);
        rd(tmc_pkg::ADDR_COUNT, 32'h0000_00FF);
        sleep <= 1'b0;
        $display("sleep freeze done");
    endtask
    // Rising select counts the first toggle, falling select only the second.
    task automatic t_pin();
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, tmc_pkg::ADDR_OPTION, s ? 32'h0000_0038 : 32'h0000_0028);
            apb(1'b1, tmc_pkg::ADDR_COUNT, '0);
            repeat (12) @(posedge clk);
            i_pin.toggle();
            rd(tmc_pkg::ADDR_COUNT, s ? 32'h0000_0000 : 32'h0000_0001);
            i_pin.toggle();
            rd(tmc_pkg::ADDR_COUNT, 32'h0000_0001);
        end
        $display("pin counting done");
    endtask

    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_rates();
        t_overflow();
        t_sleep();
        t_pin();
        print_verdict();
    end
endmodule
